/* File: include/cdr_pkg.sv */
// constants and carrier types for the recovery-loop tuning register bank
// assumes a two-wire serial host port and a single 200 MHz system clock
package cdr_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_EDGE_BW = 8'h10;
  localparam logic [7:0] REG_LOOP = 8'h13;
  localparam logic [7:0] REG_PHASE = 8'h14;
  localparam logic [7:0] REG_SLICE = 8'h15;
  localparam logic [7:0] REG_TRIM = 8'h73;

  localparam logic [7:0] RST_EDGE_BW = 8'h04;
  localparam logic [7:0] RST_LOOP = 8'h06;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_SLICE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int SLICE_EXT_BIT = 7;
  localparam int EDGE_LSB = 3;
  localparam int BW_LSB = 0;
  localparam int SLEW_LSB = 0;
  localparam int ADAPT_BIT = 2;
  localparam int PHASE_LSB = 0;
  localparam logic [6:0] SLICE_OFF = 7'h00;
  localparam logic [7:0] SLICE_MID = 8'h40;
  localparam logic signed [9:0] SLICE_EXT_MULT = 10'sh006;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] SLEW_RST = 2'h2;
  localparam logic [2:0] BW_RST = 3'h4;
  localparam logic [2:0] TRACK_RST = 3'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // arbitrary serial device address, not tied to any real part
  localparam logic [6:0] DEV_ADDR = 7'h40;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RX = 6'h04,
    ST_ACK = 6'h08,
    ST_TX = 6'h10,
    ST_RACK = 6'h20
  } cdr_fsm_t;

  typedef struct packed {
    logic slice_en;
    logic slice_ext;
    logic [6:0] slice_code;
    logic signed [9:0] slice_offset;
    logic offset_loop_en;
    logic pd_rise_en;
    logic pd_fall_en;
    logic [1:0] dll_slew;
    logic [2:0] dll_track;
    logic signed [3:0] sample_phase;
    logic [2:0] loop_bandwidth_scale;
  } cdr_ctl_t;

  typedef struct packed {
    cdr_fsm_t fsm;
    logic scl_d;
    logic sda_d;
    logic [2:0] cnt;
    logic full;
    logic [7:0] sr;
    logic [7:0] tx;
    logic rw;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_lvl;
    logic [7:0] phase_edge_and_bandwidth;
    logic [7:0] loop_control;
    logic [7:0] sampling_phase_control;
    logic [7:0] threshold_offset_control;
    cdr_ctl_t ctl;
  } cdr_st_t;

endpackage

/* File: hdl/cdr_sync2.sv */
// two-stage synchroniser for asynchronous pin levels
// assumes the input may change at any time relative to clk_sys
`timescale 1ns/100ps
module cdr_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // first stage feeds only the second stage
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '1;
      q <= '1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

/* File: hdl/cdr_tune_ctrl.sv */
// tuning register bank of the clock and data recovery loop, with its serial host port
// assumes scl/sda pins are asynchronous, trim and rate flag come from logic on clk_sys
`timescale 1ns/100ps

// How it works
// - a zero slice code turns the threshold offset off entirely.
// - normal slice scaling steps one trim unit per code, centred on code 64.
// - the extended bit multiplies the slice offset range by six.
// - the trimmed input offset reads back as a seven-bit value.
// - clearing the adaptive enable stops the duty-cycle offset loop.
// - edge choice 1 uses rising edges only, 2 falling edges only.
// - the slew field resets to 2 and tracking is (slew+1)/4 UI.
// - the slew breakpoint frequency follows data rate divided by 2500.
// - the sampling-instant offset acts only at 5.65 Gbps or above.
// - the sampling-instant offset is two's complement in 1/32 UI steps.
// - the bandwidth scale resets to 4 and scales bandwidth by value/4.
module cdr_tune_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // two-wire host port
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // device status
  input wire logic [6:0] trim_offset,
  input wire logic rate_high,
  // tuning controls
  output cdr_pkg::cdr_ctl_t tune
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pins_s;

  cdr_sync2 #(.W(2)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d({scl_i, sda_i}),
    .q(pins_s)
  );

  logic scl_s;
  logic sda_s;
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  cdr_pkg::cdr_st_t s_reg;
  cdr_pkg::cdr_st_t s_next;

  // ****************************************
  // register read mux
  // ****************************************
  function automatic logic [7:0] rd_byte(input cdr_pkg::cdr_st_t st, input logic [7:0] a,
                                         input logic [6:0] trim);
    logic [7:0] v;
    v = cdr_pkg::READ_UNMAPPED;
    unique case (a)
      cdr_pkg::REG_EDGE_BW: v = st.phase_edge_and_bandwidth;
      cdr_pkg::REG_LOOP: v = st.loop_control;
      cdr_pkg::REG_PHASE: v = st.sampling_phase_control;
      cdr_pkg::REG_SLICE: v = st.threshold_offset_control;
      cdr_pkg::REG_TRIM: v = {1'b0, trim};
      default: v = cdr_pkg::READ_UNMAPPED;
    endcase
    return v;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rd_now;
  logic [7:0] sh_in;
  logic [6:0] code;
  logic [1:0] edge_sel;
  logic signed [7:0] slice_d;
  logic signed [9:0] slice_x;

  always_comb begin
    s_next = s_reg;
    scl_rise = scl_s & ~s_reg.scl_d;
    scl_fall = ~scl_s & s_reg.scl_d;
    // start and stop are sda moves while scl stays high
    bus_start = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
    bus_stop = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
    rd_now = rd_byte(s_reg, s_reg.ptr, trim_offset);
    sh_in = {s_reg.sr[6:0], sda_s};
    s_next.scl_d = scl_s;
    s_next.sda_d = sda_s;

    // ****************************************
    // serial port state machine
    // ****************************************
    unique case (s_reg.fsm)
      cdr_pkg::ST_IDLE: begin
        s_next.sda_oe = 1'b0;
      end
      cdr_pkg::ST_ADDR, cdr_pkg::ST_RX: begin
        if (scl_rise) begin
          s_next.sr = sh_in;
          s_next.cnt = s_reg.cnt + 3'h1;
          s_next.full = (s_reg.cnt == cdr_pkg::BIT_LAST);
        end else if (scl_fall && s_reg.full) begin
          s_next.full = 1'b0;
          s_next.fsm = cdr_pkg::ST_ACK;
          s_next.sda_oe = 1'b1;
          if (s_reg.fsm == cdr_pkg::ST_ADDR) begin
            s_next.rw = s_reg.sr[0];
            s_next.first = 1'b1;
            if (s_reg.sr[7:1] != cdr_pkg::DEV_ADDR) begin
              // not our address: stay off the bus until the next start
              s_next.fsm = cdr_pkg::ST_IDLE;
              s_next.sda_oe = 1'b0;
            end
          end else if (s_reg.first) begin
            s_next.ptr = s_reg.sr;
            s_next.first = 1'b0;
          end else begin
            s_next.ptr = s_reg.ptr + 8'h01;
            unique case (s_reg.ptr)
              cdr_pkg::REG_EDGE_BW: s_next.phase_edge_and_bandwidth = s_reg.sr;
              cdr_pkg::REG_LOOP: s_next.loop_control = s_reg.sr;
              cdr_pkg::REG_PHASE: s_next.sampling_phase_control = s_reg.sr;
              cdr_pkg::REG_SLICE: s_next.threshold_offset_control = s_reg.sr;
              // read-only trim and unmapped bytes are acknowledged and dropped
              default: s_next.ptr = s_reg.ptr + 8'h01;
            endcase
          end
        end
      end
      cdr_pkg::ST_ACK: begin
        if (scl_fall) begin
          s_next.cnt = 3'h0;
          s_next.full = 1'b0;
          if (s_reg.rw) begin
            s_next.tx = rd_now;
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.sda_oe = ~rd_now[7];
            s_next.fsm = cdr_pkg::ST_TX;
          end else begin
            s_next.sda_oe = 1'b0;
            s_next.fsm = cdr_pkg::ST_RX;
          end
        end
      end
      cdr_pkg::ST_TX: begin
        if (scl_rise) begin
          s_next.cnt = s_reg.cnt + 3'h1;
          s_next.full = (s_reg.cnt == cdr_pkg::BIT_LAST);
        end else if (scl_fall) begin
          if (s_reg.full) begin
            s_next.full = 1'b0;
            s_next.sda_oe = 1'b0;
            s_next.fsm = cdr_pkg::ST_RACK;
          end else begin
            s_next.tx = {s_reg.tx[6:0], 1'b0};
            s_next.sda_oe = ~s_reg.tx[6];
          end
        end
      end
      cdr_pkg::ST_RACK: begin
        if (scl_rise) begin
          s_next.nack = sda_s;
        end else if (scl_fall) begin
          s_next.cnt = 3'h0;
          if (s_reg.nack) begin
            s_next.fsm = cdr_pkg::ST_IDLE;
          end else begin
            s_next.tx = rd_now;
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.sda_oe = ~rd_now[7];
            s_next.fsm = cdr_pkg::ST_TX;
          end
        end
      end
      default: begin
        s_next.fsm = cdr_pkg::ST_IDLE;
        s_next.sda_oe = 1'b0;
      end
    endcase

    if (bus_start) begin
      s_next.fsm = cdr_pkg::ST_ADDR;
      s_next.cnt = 3'h0;
      s_next.full = 1'b0;
      s_next.sda_oe = 1'b0;
    end else if (bus_stop) begin
      s_next.fsm = cdr_pkg::ST_IDLE;
      s_next.sda_oe = 1'b0;
    end

    // ****************************************
    // tuning outputs from the registers
    // ****************************************
    code = s_reg.threshold_offset_control[6:0];
    edge_sel = s_reg.phase_edge_and_bandwidth[cdr_pkg::EDGE_LSB +: 2];
    slice_d = $signed({1'b0, code}) - $signed(cdr_pkg::SLICE_MID);
    slice_x = 10'(slice_d);
    s_next.ctl.slice_en = (code != cdr_pkg::SLICE_OFF);
    s_next.ctl.slice_code = code;
    s_next.ctl.slice_ext = s_reg.threshold_offset_control[cdr_pkg::SLICE_EXT_BIT];
    if (code == cdr_pkg::SLICE_OFF) begin
      s_next.ctl.slice_offset = '0;
    end else if (s_reg.threshold_offset_control[cdr_pkg::SLICE_EXT_BIT]) begin
      s_next.ctl.slice_offset = 10'(slice_x * cdr_pkg::SLICE_EXT_MULT);
    end else begin
      s_next.ctl.slice_offset = slice_x;
    end
    s_next.ctl.offset_loop_en = s_reg.loop_control[cdr_pkg::ADAPT_BIT];
    s_next.ctl.pd_rise_en = (edge_sel != cdr_pkg::EDGE_FALL);
    s_next.ctl.pd_fall_en = (edge_sel != cdr_pkg::EDGE_RISE);
    s_next.ctl.dll_slew = s_reg.loop_control[cdr_pkg::SLEW_LSB +: 2];
    // breakpoint scales with rate in the loop itself
    s_next.ctl.dll_track = {1'b0, s_reg.loop_control[cdr_pkg::SLEW_LSB +: 2]} + 3'h1;
    // phase offset only at high rate
    s_next.ctl.sample_phase = rate_high ?
      $signed(s_reg.sampling_phase_control[cdr_pkg::PHASE_LSB +: 4]) : 4'sh0;
    s_next.ctl.loop_bandwidth_scale = s_reg.phase_edge_and_bandwidth[cdr_pkg::BW_LSB +: 3];
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.fsm <= cdr_pkg::ST_IDLE;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
      s_reg.phase_edge_and_bandwidth <= cdr_pkg::RST_EDGE_BW;
      s_reg.loop_control <= cdr_pkg::RST_LOOP;
      s_reg.sampling_phase_control <= cdr_pkg::RST_PHASE;
      s_reg.threshold_offset_control <= cdr_pkg::RST_SLICE;
      s_reg.ctl.offset_loop_en <= 1'b1;
      s_reg.ctl.pd_rise_en <= 1'b1;
      s_reg.ctl.pd_fall_en <= 1'b1;
      s_reg.ctl.dll_slew <= cdr_pkg::SLEW_RST;
      s_reg.ctl.dll_track <= cdr_pkg::TRACK_RST;
      s_reg.ctl.loop_bandwidth_scale <= cdr_pkg::BW_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // open-drain: the pad only ever pulls low
  assign sda_o = s_reg.sda_lvl;
  assign sda_oe = s_reg.sda_oe;
  assign tune = s_reg.ctl;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  slice_off_a: assert property (
    ##1 (tune.slice_en == ($past(s_reg.threshold_offset_control[6:0]) != 7'h00)))
    else $error("slice enable does not follow zero code");
  slice_norm_a: assert property (
    ##1 ($past(s_reg.threshold_offset_control) == 8'h41) |-> (tune.slice_offset == 10'sh001))
    else $error("normal slice step wrong");
  slice_ext_a: assert property (
    ##1 ($past(s_reg.threshold_offset_control) == 8'h81) |-> (tune.slice_offset == -10'sd378))
    else $error("extended slice scale wrong");
  trim_read_a: assert property (
    (s_reg.fsm == cdr_pkg::ST_ACK && s_reg.rw && scl_fall && s_reg.ptr == cdr_pkg::REG_TRIM)
      |=> (s_reg.tx == {1'b0, $past(trim_offset)}))
    else $error("trim readback byte wrong");
  loop_gate_a: assert property (
    $fell(s_reg.loop_control[cdr_pkg::ADAPT_BIT]) |=> !tune.offset_loop_en)
    else $error("offset loop not stopped");
  edge_rise_a: assert property (
    (s_reg.phase_edge_and_bandwidth[4:3] == 2'h1) |=> (tune.pd_rise_en && !tune.pd_fall_en))
    else $error("rising-only edge select wrong");
  edge_fall_a: assert property (
    (s_reg.phase_edge_and_bandwidth[4:3] == 2'h2) |=> (!tune.pd_rise_en && tune.pd_fall_en))
    else $error("falling-only edge select wrong");
  slew_track_a: assert property (
    (s_reg.loop_control[1:0] == 2'h2) |=> (tune.dll_track == 3'h3))
    else $error("slew tracking wrong");
  phase_gate_a: assert property (
    !rate_high |=> (tune.sample_phase == 4'sh0))
    else $error("sample phase active at low rate");
  bw_follow_a: assert property (
    $changed(s_reg.phase_edge_and_bandwidth[2:0])
      |=> (tune.loop_bandwidth_scale == $past(s_reg.phase_edge_and_bandwidth[2:0])))
    else $error("bandwidth scale not applied");
  addr_quiet_a: assert property (
    (s_reg.fsm == cdr_pkg::ST_ADDR && scl_fall && s_reg.full && s_reg.sr[7:1] != cdr_pkg::DEV_ADDR)
      |=> !s_reg.sda_oe [*2])
    else $error("drove bus for foreign address");

endmodule

/* File: tb/cdr_host_model.sv */
// host controller model for the tuning bank's two-wire port
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/100ps
module cdr_host_model (
  // clock
  input wire logic clk_sys,
  // serial pins
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // six clocks a phase, clear of the two the pin synchroniser needs
  localparam int PH = 6;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold();
    repeat (PH) @(negedge clk_sys);
  endtask

  // also a repeated start: released data rises before the clock does
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
  endtask

  task automatic stop();
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask

  // data moves a full phase after the clock falls, never beside it
  task automatic put_bit(input logic b, output logic r);
    hold();
    sda_low = !b;
    hold();
    scl = 1'b1;
    hold();
    r = sda_line;
    scl = 1'b0;
  endtask

  // msb first, then a released ninth bit whose level is returned
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], rx[i]);
    end
    put_bit(1'b1, nak);
  endtask
endmodule

/* File: tb/cdr_tune_ctrl_tb.sv */
// self-checking bench for the tuning register bank
// assumes cdr_host_model drives the serial port; line has a pull-up
`timescale 1ns/100ps
module cdr_tune_ctrl_tb;
  logic clk_sys = 1'b0;
  logic nrst;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe;
  logic [6:0] trim_offset;
  logic rate_high;
  cdr_pkg::cdr_ctl_t tune;
  integer seed;
  int fail_count;
  int n_compared;
  logic [7:0] v;
  logic [7:0] rv;
  logic nak;
  logic [7:0] corner [8] = '{8'h00, 8'h01, 8'h40, 8'h41, 8'h7F, 8'h80, 8'h81, 8'hFF};
  // open drain: low while either party pulls
  wire sda_line = !(sda_low || (sda_oe && !sda_o));

  always #2.5 clk_sys = ~clk_sys;

  cdr_tune_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .trim_offset(trim_offset), .rate_high(rate_high),
    .tune(tune));
  cdr_host_model i_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic signed [9:0] slice_exp(input logic [7:0] c);
    logic signed [9:0] d;
    d = signed'({3'h0, c[6:0]}) - 10'sh040;
    if (c[6:0] == 7'h00) begin
      return 10'sh000;
    end
    return c[7] ? d * 10'sh006 : d;
  endfunction

  task automatic open_w(input logic [7:0] ptr);
    i_host.start();
    i_host.xfer({cdr_pkg::DEV_ADDR, 1'b0}, rv, nak);
    chk("addr ack", 16'(nak), 16'h0);
    i_host.xfer(ptr, rv, nak);
    chk("ptr ack", 16'(nak), 16'h0);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    open_w(ptr);
    i_host.xfer(d, rv, nak);
    chk("data ack", 16'(nak), 16'h0);
    i_host.stop();
  endtask

  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    open_w(ptr);
    i_host.start();
    i_host.xfer({cdr_pkg::DEV_ADDR, 1'b1}, rv, nak);
    chk("rd addr ack", 16'(nak), 16'h0);
    i_host.xfer(8'hFF, d, nak);
    i_host.stop();
  endtask

  // a hung port must not stall the run
  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    $display("BAD watchdog expected done seen hang");
    conclude();
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    seed = 32'h021e;
    nrst = 1'b0;
    trim_offset = 7'h00;
    rate_high = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);

    chk("slew rst", 16'(tune.dll_slew), 16'h2);
    chk("track rst", 16'(tune.dll_track), 16'h3);
    chk("bw rst", 16'(tune.loop_bandwidth_scale), 16'h4);
    rd(8'h10, v);
    chk("bw reg rst", 16'(v[2:0]), 16'h4);
    rd(8'h13, v);
    chk("slew reg rst", 16'(v[1:0]), 16'h2);
    $display("reset test done");

    for (int i = 0; i < 15; i++) begin
      v = (i < 8) ? corner[i] : 8'($random(seed));
      wr(8'h15, v);
      chk("slice off", 16'(tune.slice_offset), 16'(slice_exp(v)));
      chk("slice en", 16'(tune.slice_en), 16'(v[6:0] != 7'h00));
      chk("slice ext", 16'(tune.slice_ext), 16'(v[7]));
      chk("slice code", 16'(tune.slice_code), 16'(v[6:0]));
    end
    $display("slice test done");

    for (int s = 0; s < 4; s++) begin
      v = {5'($random(seed)), 1'(s[0]), 2'(s)};
      wr(8'h13, v);
      chk("adapt en", 16'(tune.offset_loop_en), 16'(v[2]));
      chk("slew", 16'(tune.dll_slew), 16'(s));
      chk("track", 16'(tune.dll_track), 16'(s + 1));
      rd(8'h13, rv);
      chk("loop reg", 16'(rv[2:0]), 16'(v[2:0]));
    end
    $display("loop test done");

    for (int e = 0; e < 4; e++) begin
      v = 8'($random(seed));
      v[2:0] = (v[2:0] == 3'h0) ? 3'h1 : v[2:0];
      wr(8'h10, {3'h0, 2'(e), v[2:0]});
      chk("rise en", 16'(tune.pd_rise_en), 16'(e != 2));
      chk("fall en", 16'(tune.pd_fall_en), 16'(e != 1));
      chk("bw", 16'(tune.loop_bandwidth_scale), 16'(v[2:0]));
    end
    $display("edge test done");

    // manual slice: adaptive off, single edge
    wr(8'h13, 8'h02);
    wr(8'h10, 8'h0C);
    trim_offset = {1'b0, 6'($random(seed))};
    rd(8'h73, v);
    chk("trim rd", 16'(v), 16'({1'b0, trim_offset}));
    // code from wanted level minus trim
    wr(8'h15, 8'd84 - v);
    chk("manual slice", 16'(tune.slice_offset), 16'(10'sd20 - signed'({3'h0, trim_offset})));
    wr(8'h73, 8'h55);
    rd(8'h73, rv);
    chk("trim ro", 16'(rv), 16'(v));
    rd(8'h20, rv);
    chk("unmapped", 16'(rv), 16'h0);
    i_host.start();
    i_host.xfer({7'h41, 1'b0}, rv, nak);
    chk("foreign nak", 16'(nak), 16'h1);
    i_host.stop();
    $display("trim test done");

    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      rate_high = i[0];
      wr(8'h14, v);
      chk("phase", 16'(tune.sample_phase), 16'(rate_high ? signed'(v[3:0]) : 4'sh0));
      rate_high = !rate_high;
      repeat (3) @(negedge clk_sys);
      chk("phase rate", 16'(tune.sample_phase), 16'(rate_high ? signed'(v[3:0]) : 4'sh0));
    end
    $display("phase test done");

    // a mid-run reset must bring every written control back to its default
    @(negedge clk_sys);
    nrst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("mid rst adapt", 16'(tune.offset_loop_en), 16'h1);
    chk("mid rst slice", 16'(tune.slice_en), 16'h0);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("mid rst slew", 16'(tune.dll_slew), 16'(cdr_pkg::SLEW_RST));
    chk("mid rst bw", 16'(tune.loop_bandwidth_scale), 16'(cdr_pkg::BW_RST));
    rd(8'h14, v);
    chk("mid rst phase reg", 16'(v), 16'(cdr_pkg::RST_PHASE));
    rd(8'h15, v);
    chk("mid rst slice reg", 16'(v), 16'(cdr_pkg::RST_SLICE));
    $display("mid reset test done");
    conclude();
  end
endmodule
